// ==== logic/pointer_stack_instruction_exec.sv ====
// execution of indexed move, literal push, pointer subtract and subtract-return
`timescale 1ns/1ps
module pointer_stack_instruction_exec #(
  parameter logic [7:0] PUSH_OPCODE_HI = ptr_exec_pkg::OP_PUSH_HI_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic q4_en,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] mem_rd_data,
  input wire logic [ptr_exec_pkg::PC_W-1:0] return_stack_top,
  output logic [ptr_exec_pkg::ADDR_W-1:0] mem_rd_addr,
  output logic mem_wr_en,
  output logic [ptr_exec_pkg::ADDR_W-1:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  output logic pc_load,
  output logic [ptr_exec_pkg::PC_W-1:0] pc_load_value,
  output logic return_pop,
  output logic busy,
  output logic [ptr_exec_pkg::ADDR_W-1:0] ptr0,
  output logic [ptr_exec_pkg::ADDR_W-1:0] ptr1,
  output logic [ptr_exec_pkg::ADDR_W-1:0] stack_pointer_two
);
  import ptr_exec_pkg::*;

  // ***********************************************************
  // decode helpers
  // ***********************************************************
  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect = (a >= INDIRECT_BASE2 && a < INDIRECT_BASE2 + INDIRECT_SPAN)
               || (a >= INDIRECT_BASE1 && a < INDIRECT_BASE1 + INDIRECT_SPAN)
               || (a >= INDIRECT_BASE0 && a < INDIRECT_BASE0 + INDIRECT_SPAN);
  endfunction

  function automatic logic [11:0] index_addr(input logic [11:0] base, input logic [6:0] off);
    index_addr = base + {5'h0_0, off};
  endfunction

  exec_state_t state_reg;
  logic [7:0] move_data_reg;
  logic [11:0] ptr_sel_val;
  logic [11:0] sub_result;
  logic [7:0] sub_amount;
  logic [11:0] src_addr;
  logic [11:0] dst_addr;
  logic [7:0] hi;
  logic [1:0] sel;
  logic is_move1;
  logic is_push;
  logic is_sub;
  logic is_subret;
  logic is_move2;
  logic idle;
  logic go;

  // ***********************************************************
  // instruction decode
  // ***********************************************************
  assign go = instr_valid && q4_en;
  assign idle = (state_reg == ST_IDLE);
  assign hi = instr_word[15:8];
  assign sel = instr_word[7:6];
  assign is_sub = (hi == OP_SUB_HI) && (sel != SEL_RETURN);
  assign is_subret = (hi == OP_SUB_HI) && (sel == SEL_RETURN);
  assign is_push = (hi == PUSH_OPCODE_HI);
  assign is_move1 = (hi == OP_MOVE_HI) && instr_word[7];
  // second move word carries the destination offset
  assign is_move2 = (instr_word[15:12] == OP_SECOND_NIB);
  assign src_addr = index_addr(stack_pointer_two, instr_word[6:0]);
  assign dst_addr = index_addr(stack_pointer_two, instr_word[6:0]);

  // ***********************************************************
  // pointer select and subtract
  // ***********************************************************
  always_comb begin
    unique case (sel)
      2'b00: ptr_sel_val = ptr0;
      2'b01: ptr_sel_val = ptr1;
      default: ptr_sel_val = stack_pointer_two;
    endcase
  end

  // push subtracts one, others the 6-bit literal
  assign sub_amount = is_push ? ONE_ADDR[7:0] : {2'b00, instr_word[5:0]};

  ptr_sub_unit u_sub (
    .ptr_in(is_push ? stack_pointer_two : ptr_sel_val),
    .amount(sub_amount),
    .ptr_out(sub_result)
  );

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
    end else if (q4_en) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (instr_valid && is_move1) begin
            state_reg <= ST_MOVE2;
          end else if (instr_valid && is_subret) begin
            state_reg <= ST_RET_NOP;
          end
        end
        // waits for a valid second word
        ST_MOVE2: state_reg <= instr_valid ? ST_IDLE : ST_MOVE2;
        ST_RET_NOP: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // second-cycle status
  // ***********************************************************
  // reports the state one clock late
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_reg != ST_IDLE);
    end
  end

  // ***********************************************************
  // move data path
  // ***********************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mem_rd_addr <= PTR_RESET;
    end else if (instr_valid && is_move1 && idle) begin
      // runs ahead of q4 so read data has settled when it is taken
      mem_rd_addr <= src_addr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      move_data_reg <= INDIRECT_READ_VALUE;
    end else if (go && is_move1 && idle) begin
      move_data_reg <= is_indirect(mem_rd_addr) ? INDIRECT_READ_VALUE : mem_rd_data;
    end
  end

  // ***********************************************************
  // memory writes
  // ***********************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mem_wr_en <= 1'b0;
      mem_wr_addr <= PTR_RESET;
      mem_wr_data <= INDIRECT_READ_VALUE;
    end else begin
      // default low keeps the write a one-cycle pulse
      mem_wr_en <= 1'b0;
      if (go && state_reg == ST_MOVE2 && is_move2) begin
        mem_wr_en <= !is_indirect(dst_addr);
        mem_wr_addr <= dst_addr;
        mem_wr_data <= move_data_reg;
      end else if (go && idle && is_push) begin
        mem_wr_en <= 1'b1;
        mem_wr_addr <= stack_pointer_two;
        mem_wr_data <= instr_word[7:0];
      end
    end
  end

  // ***********************************************************
  // pointer registers
  // ***********************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ptr0 <= PTR_RESET;
      ptr1 <= PTR_RESET;
      stack_pointer_two <= PTR_RESET;
    end else if (go && idle) begin
      if (is_push || is_subret) begin
        stack_pointer_two <= sub_result;
      end else if (is_sub) begin
        unique case (sel)
          2'b00: ptr0 <= sub_result;
          2'b01: ptr1 <= sub_result;
          default: stack_pointer_two <= sub_result;
        endcase
      end
    end
  end

  // ***********************************************************
  // return
  // ***********************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pc_load <= 1'b0;
      return_pop <= 1'b0;
      pc_load_value <= '0;
    end else begin
      pc_load <= 1'b0;
      return_pop <= 1'b0;
      // pop pulses with the load so the stack steps once
      if (go && idle && is_subret) begin
        // load program counter from return top
        pc_load <= 1'b1;
        return_pop <= 1'b1;
        pc_load_value <= return_stack_top;
      end
    end
  end
endmodule

// ==== logic/ptr_exec_pkg.sv ====
// constants and types for the pointer and stack instruction execution block
// Summary of operation
// - move addresses are pointer two plus separate 7-bit offsets from each word.
// - both move addresses span the full 12-bit data space 000h to FFFh.
// - move source on an indirect register supplies 00h as the data.
// - move destination on an indirect register makes the instruction a no-operation.
// - literal push stores its 8-bit value at the address in pointer two.
// - after the push store, pointer two decreases by exactly one.
// - subtract-from-pointer takes a 6-bit literal from pointer 0, 1 or 2.
// - subtract-from-pointer decodes from upper bits 1110 1001, then select and literal.
// - select field 11 means subtract-and-return, acting only on pointer two.
// - subtract-and-return takes its 6-bit literal from pointer two.
// - subtract-and-return then loads the program counter from the return stack top.
// - subtract-and-return lasts two cycles, the second a no-operation.
package ptr_exec_pkg;
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam logic [7:0] OP_MOVE_HI = 8'h00_EB;
  localparam logic [3:0] OP_SECOND_NIB = 4'h0_F;
  localparam logic [7:0] OP_SUB_HI = 8'h00_E9;
  localparam logic [7:0] OP_PUSH_HI_DEFAULT = 8'h00_FA;
  localparam logic [1:0] SEL_RETURN = 2'h0_3;
  localparam logic [1:0] SEL_PTR_TWO = 2'h0_2;
  localparam logic [11:0] PTR_RESET = 12'h0_000;
  localparam logic [7:0] INDIRECT_READ_VALUE = 8'h00_00;
  localparam logic [11:0] ONE_ADDR = 12'h0_001;
  // indirect-access registers: three banks of five at the top of the space
  localparam logic [11:0] INDIRECT_BASE0 = 12'h0_FEB;
  localparam logic [11:0] INDIRECT_BASE1 = 12'h0_FE3;
  localparam logic [11:0] INDIRECT_BASE2 = 12'h0_FDB;
  localparam logic [11:0] INDIRECT_SPAN = 12'h0_005;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE2 = 2'b01,
    ST_RET_NOP = 2'b10
  } exec_state_t;
endpackage

// ==== logic/ptr_sub_unit.sv ====
// wrapping 12-bit pointer subtractor shared by the pointer instructions
`timescale 1ns/1ps
module ptr_sub_unit (
  input wire logic [11:0] ptr_in,
  input wire logic [7:0] amount,
  output logic [11:0] ptr_out
);
  // 12-bit wrap, no flags produced
  assign ptr_out = ptr_in - {4'h0_0, amount};
endmodule

// ==== test/ptr_exec_mem_model.sv ====
// data memory and return stack model facing the execution block
`timescale 1ns/1ps
module ptr_exec_mem_model #(
  parameter logic [20:0] RET_TOP = 21'h0_1234
) (
  input wire logic ref_clk,
  input wire logic [11:0] mem_rd_addr,
  input wire logic mem_wr_en,
  input wire logic [11:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  input wire logic return_pop,
  output logic [7:0] mem_rd_data,
  output logic [20:0] return_stack_top
);
  logic [7:0] mem [4096];
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
  initial return_stack_top = RET_TOP;
  assign mem_rd_data = mem[mem_rd_addr];
  always @(posedge ref_clk) begin
    if (mem_wr_en) mem[mem_wr_addr] <= mem_wr_data;
    if (return_pop) return_stack_top <= return_stack_top + 21'h0_0010;
  end
endmodule

// ==== test/ptr_exec_assertions.sv ====
// assertions on the ports of the pointer and stack execution block
`timescale 1ns/1ps
module ptr_exec_checker
  import ptr_exec_pkg::*;
#(parameter logic [7:0] PUSH_OPCODE_HI = OP_PUSH_HI_DEFAULT) (
  input wire logic ref_clk, rst_b, q4_en, instr_valid, mem_wr_en, pc_load, return_pop,
  input wire logic [15:0] instr_word,
  input wire logic [20:0] return_stack_top, pc_load_value,
  input wire logic [11:0] mem_wr_addr, ptr0, ptr1, stack_pointer_two,
  input wire logic [7:0] mem_wr_data
);
  logic ret_wait;
  wire go = q4_en && instr_valid;
  wire sub = go && !ret_wait && instr_word[15:8] == OP_SUB_HI;
  wire push = go && !ret_wait && instr_word[15:8] == PUSH_OPCODE_HI;
  wire [1:0] sel = instr_word[7:6];
  wire [11:0] k6 = {6'h00, instr_word[5:0]};
  always_ff @(posedge ref_clk) begin
    if (!rst_b) ret_wait <= 1'b0;
    else if (go) ret_wait <= sub && sel == SEL_RETURN;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_push_store: assert property (push |=> mem_wr_en &&
    mem_wr_addr == $past(stack_pointer_two) && mem_wr_data == $past(instr_word[7:0]))
    else $error("push store wrong");
  a_push_dec: assert property (push |=>
    stack_pointer_two == $past(stack_pointer_two) - 12'h001) else $error("push step wrong");
  a_sub_zero: assert property (sub && sel == 2'h0 |=> ptr0 == $past(ptr0) - $past(k6))
    else $error("pointer zero subtract wrong");
  a_sub_one: assert property (sub && sel == 2'h1 |=>
    ptr1 == $past(ptr1) - $past(k6) && $stable(ptr0)) else $error("pointer one wrong");
  a_sub_two: assert property (sub && sel == SEL_PTR_TWO |=>
    stack_pointer_two == $past(stack_pointer_two) - $past(k6)) else $error("pointer two wrong");
  a_ret_load: assert property (sub && sel == SEL_RETURN |=> pc_load && return_pop &&
    pc_load_value == $past(return_stack_top) &&
    stack_pointer_two == $past(stack_pointer_two) - $past(k6)) else $error("return wrong");
  a_ret_nop: assert property (go && ret_wait |=> !mem_wr_en && !pc_load &&
    $stable(stack_pointer_two)) else $error("second return cycle not idle");
  a_quiet_gap: assert property (!q4_en |=> !mem_wr_en && !pc_load && !return_pop)
    else $error("pulse without instruction edge");
  c_push: cover property (push ##1 mem_wr_en);
  c_ret: cover property (pc_load);
  c_move: cover property (go && instr_word[15:12] == 4'hF ##1 mem_wr_en);
endmodule
bind pointer_stack_instruction_exec ptr_exec_checker #(.PUSH_OPCODE_HI(PUSH_OPCODE_HI)) chk_i (
  .ref_clk, .rst_b, .q4_en, .instr_valid, .mem_wr_en, .pc_load, .return_pop, .instr_word,
  .return_stack_top, .pc_load_value, .mem_wr_addr, .ptr0, .ptr1, .stack_pointer_two,
  .mem_wr_data);

// ==== test/pointer_stack_instruction_exec_tb.sv ====
// self-checking bench for the pointer and stack execution block
`timescale 1ns/1ps
module pointer_stack_instruction_exec_tb;
  import ptr_exec_pkg::*;
  typedef struct {logic [15:0] w; logic [11:0] p0, p1, sp; logic wr, ld;} row_t;
  logic ref_clk = 0, rst_b = 0, q4_en = 0, instr_valid = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] mem_rd_data, mem_wr_data;
  logic [20:0] return_stack_top, pc_load_value, top_old;
  logic [11:0] mem_rd_addr, mem_wr_addr, ptr0, ptr1, stack_pointer_two, sp_old;
  logic mem_wr_en, pc_load, return_pop, busy;
  int err_count = 0, num_checks = 0;
  row_t rows [6] = '{
    '{16'hE905, 12'hFFB, 12'h000, 12'h000, 1'b0, 1'b0},
    '{16'hE97F, 12'hFFB, 12'hFC1, 12'h000, 1'b0, 1'b0},
    '{16'hE981, 12'hFFB, 12'hFC1, 12'hFFF, 1'b0, 1'b0},
    '{16'hFA33, 12'hFFB, 12'hFC1, 12'hFFE, 1'b1, 1'b0},
    '{16'hE9C2, 12'hFFB, 12'hFC1, 12'hFFC, 1'b0, 1'b1},
    '{16'hE99C, 12'hFFB, 12'hFC1, 12'hFE0, 1'b0, 1'b0}};
  always #2 ref_clk = ~ref_clk;
  pointer_stack_instruction_exec dut (.ref_clk, .rst_b, .q4_en, .instr_valid, .instr_word,
    .mem_rd_data, .return_stack_top, .mem_rd_addr, .mem_wr_en, .mem_wr_addr, .mem_wr_data,
    .pc_load, .pc_load_value, .return_pop, .busy, .ptr0, .ptr1, .stack_pointer_two);
  ptr_exec_mem_model mem_i (.ref_clk, .mem_rd_addr, .mem_wr_en, .mem_wr_addr, .mem_wr_data,
    .return_pop, .mem_rd_data, .return_stack_top);
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  // word held two cycles, then taken on the q4 edge
  task automatic exec(input logic [15:0] w);
    @(posedge ref_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    sp_old = stack_pointer_two;
    top_old = return_stack_top;
    @(posedge ref_clk);
    q4_en <= 1'b1;
    @(posedge ref_clk);
    q4_en <= 1'b0;
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic mv(input logic [6:0] zs, zd, input logic wr, input logic [11:0] s, a,
    input logic [7:0] d);
    exec({8'hEB, 1'b1, zs});
    chk(mem_rd_addr === s && busy === 1'b0, "move source address");
    exec({8'hF0, 1'b0, zd});
    chk(busy === 1'b1, "move second cycle status");
    chk(mem_wr_en === wr, "move write enable");
    if (wr) chk(mem_wr_addr === a && mem_wr_data === d, "move address or data");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    chk({ptr0, ptr1, stack_pointer_two, mem_wr_en, pc_load} === '0, "reset");
    @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      exec(rows[i].w);
      chk(ptr0 === rows[i].p0 && ptr1 === rows[i].p1, "pointer select");
      chk(stack_pointer_two === rows[i].sp, "pointer two");
      chk(mem_wr_en === rows[i].wr && pc_load === rows[i].ld, "pulse kind");
      if (rows[i].wr) chk(mem_wr_addr === sp_old && mem_wr_data === rows[i].w[7:0], "push");
      if (rows[i].ld) begin
        chk(pc_load_value === top_old && return_pop === 1'b1, "return");
        exec(16'hFA77);
        chk(mem_wr_en === 1'b0 && stack_pointer_two === rows[i].sp, "idle cycle");
        chk(busy === 1'b1, "return second cycle status");
      end
    end
    // destinations stay clear of program counter and return top bytes
    mv(7'h1F, 7'h01, 1'b1, 12'hFFF, 12'hFE1, 8'h33);
    mv(7'h1F, 7'h7F, 1'b1, 12'hFFF, 12'h05F, 8'h33);
    mv(7'h0B, 7'h02, 1'b1, 12'hFEB, 12'hFE2, 8'h00);
    mv(7'h00, 7'h03, 1'b0, 12'hFE0, 12'h000, 8'h00);
    finish_test();
  end
endmodule
